// ==== bench/tb_dual_register_logic_cell.sv ====
/*
  Self-checking testbench of the dual register logic cell block.
  Assumes the design files and drlc_cfg.svh are compiled and on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drlc_cfg.svh"

module tb_dual_register_logic_cell;
  logic        clk = 0;
  logic        reset = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_clk = 0;
  logic [9:0]  pin_in = 10'h000;
  logic        preload_hv = 0;
  logic        preload_select = 0;
  logic [19:0] sum_term = 20'h0_0000;
  logic [19:0] clk_term = 20'h0_0000;
  logic [19:0] areset_term = 20'h0_0000;
  logic        preset_term = 0;
  logic [9:0]  oe_term = 10'h000;
  logic [9:0]  pin_out;
  logic [9:0]  pin_oe;
  logic [9:0]  pin_to_array;
  logic [19:0] reg_feedback;
  logic [31:0] rd;
  logic        er;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;

  drlc_top drlc_top_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_clk(pin_clk), .pin_in(pin_in), .preload_hv(preload_hv), .preload_select(preload_select),
    .sum_term(sum_term), .clk_term(clk_term), .areset_term(areset_term), .preset_term(preset_term),
    .oe_term(oe_term), .pin_out(pin_out), .pin_oe(pin_oe), .pin_to_array(pin_to_array),
    .reg_feedback(reg_feedback));

  always #50 clk = ~clk;

  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      errors = errors + 1;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic pulse(input logic [19:0] m);
    @(posedge clk);
    clk_term <= m;
    @(posedge clk);
    clk_term <= 20'h0_0000;
    @(posedge clk);
  endtask

  task automatic t_reset();
    chk("feedback", 32'h0000_0000, reg_feedback);
    chk("pin_out", 32'h0000_0000, pin_out);
    apb(0, 12'h000, 32'h0000_0000);
    chk("ctrl", 32'h0000_0000, rd);
    $display("test reset done");
  endtask

  task automatic t_dt();
    sum_term <= 20'h5_5555;
    pulse(20'hF_FFFF);
    chk("d capture", 32'h0005_5555, reg_feedback);
    chk("pin_out", 32'h0000_03FF, pin_out);
    apb(1, 12'h004, 32'h000F_FFFF);
    sum_term <= 20'hF_00FF;
    pulse(20'hF_FFFF);
    chk("t toggle", 32'h000A_55AA, reg_feedback);
    apb(1, 12'h004, 32'h0000_0000);
    $display("test d and t done");
  endtask

  task automatic t_preset_reset();
    sum_term <= 20'h0_0000;
    preset_term <= 1;
    pulse(20'hF_FFFF);
    chk("preset", 32'h000F_FFFF, reg_feedback);
    preset_term <= 0;
    @(posedge clk);
    areset_term <= 20'h0_F00F;
    @(posedge clk);
    areset_term <= 20'h0_0000;
    @(posedge clk);
    chk("areset", 32'h000F_0FF0, reg_feedback);
    areset_term <= 20'hF_FFFF;
    pulse(20'hF_FFFF);
    areset_term <= 20'h0_0000;
    chk("areset wins", 32'h0000_0000, reg_feedback);
    $display("test preset and reset done");
  endtask

  task automatic t_preload();
    preload_hv <= 1;
    oe_term <= 10'h3FF;
    pin_in <= 10'h2D3;
    sum_term <= 20'hF_FFFF;
    repeat (4) @(posedge clk);
    chk("oe in preload", 32'h0000_0000, pin_oe);
    chk("pin path", 32'h0000_02D3, pin_to_array);
    pulse(20'hF_FFFF);
    chk("preload even", 32'h0004_5105, reg_feedback);
    chk("pin_out", 32'h0000_02D3, pin_out);
    apb(0, 12'h00C, 32'h0000_0000);
    chk("state", 32'h0004_5105, rd);
    apb(0, 12'h010, 32'h0000_0000);
    chk("pins", 32'h0000_02D3, rd);
    preload_select <= 1;
    pin_in <= 10'h3FF;
    repeat (4) @(posedge clk);
    pulse(20'hF_FFFF);
    chk("preload odd", 32'h000E_FBAF, reg_feedback);
    preload_hv <= 0;
    oe_term <= 10'h2A5;
    repeat (4) @(posedge clk);
    chk("oe", 32'h0000_02A5, pin_oe);
    $display("test preload done");
  endtask

  task automatic t_clk_legacy();
    areset_term <= 20'hF_FFFF;
    sum_term <= 20'hF_FFFF;
    apb(1, 12'h008, 32'h0000_0001);
    areset_term <= 20'h0_0000;
    pulse(20'hF_FFFF);
    chk("pin clock hold", 32'h000F_FFFE, reg_feedback);
    pin_clk <= 1;
    repeat (5) @(posedge clk);
    chk("pin clock", 32'h000F_FFFF, reg_feedback);
    pin_clk <= 0;
    areset_term <= 20'hF_FFFF;
    apb(1, 12'h000, 32'h0000_0001);
    apb(1, 12'h004, 32'h000F_FFFF);
    areset_term <= 20'h0_0000;
    pulse(20'hF_FFFF);
    chk("legacy", 32'h0005_5555, reg_feedback);
    pulse(20'hF_FFFF);
    chk("legacy no t", 32'h0005_5555, reg_feedback);
    $display("test clock and legacy done");
  endtask

  task automatic t_secure();
    apb(1, 12'h004, 32'h0000_0000);
    apb(1, 12'h000, 32'h0000_0002);
    apb(0, 12'h004, 32'h0000_0000);
    chk("secured dt", 32'h000F_FFFF, rd);
    apb(0, 12'h008, 32'h0000_0000);
    chk("secured clk", 32'h000F_FFFF, rd);
    apb(1, 12'h000, 32'h0000_0000);
    apb(0, 12'h000, 32'h0000_0000);
    chk("secure sticks", 32'h0000_0002, rd);
    apb(0, 12'h020, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0, er});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test secure done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    t_reset();
    t_dt();
    t_preset_reset();
    t_preload();
    t_clk_legacy();
    t_secure();
    final_report();
  end
endmodule
`default_nettype wire

// ==== design/drlc_cfg.svh ====
/*
  Constants of the dual register logic cell block: cell counts, register
  offsets, control field positions and reset values.
  Assumes it is included by its bare name from the design files.
*/
`ifndef DRLC_CFG_SVH
`define DRLC_CFG_SVH

`define DRLC_CELLS        10
`define DRLC_REGS         20

`define DRLC_OFF_CTRL     12'h000
`define DRLC_OFF_DTCFG    12'h004
`define DRLC_OFF_CLKSEL   12'h008
`define DRLC_OFF_STATE    12'h00C
`define DRLC_OFF_PINS     12'h010

`define DRLC_CTRL_LEGACY  0
`define DRLC_CTRL_SECURE  1

`define DRLC_RST_CTRL     2'h0
`define DRLC_RST_CFG      20'h0_0000
`define DRLC_ODD_MASK     20'hA_AAAA

`endif

// ==== design/drlc_pkg.sv ====
/*
  Types of the dual register logic cell block.
  Assumes drlc_cfg.svh sits on the include path.
*/
`default_nettype none
`include "drlc_cfg.svh"

package drlc_pkg;

  typedef struct packed {
    logic                     hv;
    logic                     sel;
    logic                     clk;
    logic [`DRLC_CELLS-1:0]   io;
  } drlc_pins_s;

  typedef struct packed {
    logic secure;
    logic legacy;
  } drlc_ctrl_s;

endpackage
`default_nettype wire

// ==== design/drlc_top.sv ====
/*
  Output logic cells of a small programmable logic device: twenty D/T
  flip-flops in ten cells, their clock choice, reset, preset, preload and
  pin enables, with an APB slave for configuration and status.
  Assumes the product terms come from logic on clk and the pins from outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drlc_cfg.svh"

module drlc_top #(
  parameter int AW = 12
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [AW-1:0]           paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic                    pin_clk,
  input  wire logic [`DRLC_CELLS-1:0]  pin_in,
  input  wire logic                    preload_hv,
  input  wire logic                    preload_select,
  input  wire logic [`DRLC_REGS-1:0]   sum_term,
  input  wire logic [`DRLC_REGS-1:0]   clk_term,
  input  wire logic [`DRLC_REGS-1:0]   areset_term,
  input  wire logic                    preset_term,
  input  wire logic [`DRLC_CELLS-1:0]  oe_term,
  output var  logic [`DRLC_CELLS-1:0]  pin_out,
  output var  logic [`DRLC_CELLS-1:0]  pin_oe,
  output var  logic [`DRLC_CELLS-1:0]  pin_to_array,
  output var  logic [`DRLC_REGS-1:0]   reg_feedback
);

  localparam int NR = `DRLC_REGS;
  localparam int NC = `DRLC_CELLS;

  drlc_pkg::drlc_pins_s pins_meta;
  drlc_pkg::drlc_pins_s pins_sync;
  drlc_pkg::drlc_pins_s pins_raw;
  drlc_pkg::drlc_ctrl_s ctrl;
  logic                 pclk_prev;
  logic [NR-1:0]        clk_term_prev;
  logic [NR-1:0]        dt_cfg;
  logic [NR-1:0]        clk_sel;
  logic [NR-1:0]        q;
  logic [NR-1:0]        next_q;
  logic [NR-1:0]        ev;
  logic [NR-1:0]        t_eff;
  logic                 pl_act;
  logic                 pin_edge;
  logic                 acc;

  // Pins come from outside and pass two flip-flops before use.
  assign pins_raw = '{hv: preload_hv, sel: preload_select, clk: pin_clk, io: pin_in};

  always_ff @(posedge clk) begin
    if (reset) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pclk_prev     <= 1'b0;
      clk_term_prev <= '0;
    end else begin
      pclk_prev     <= pins_sync.clk;
      clk_term_prev <= clk_term;
    end
  end

  assign pl_act   = pins_sync.hv;
  assign pin_edge = pins_sync.clk & ~pclk_prev;
  assign t_eff    = dt_cfg & ~{NR{ctrl.legacy}};

  generate
    for (genvar i = 0; i < NR; i++) begin : g_ff
      localparam logic ODD = 1'(i % 2);
      logic use_pin;
      assign use_pin = clk_sel[i] & ~ctrl.legacy;
      // The clock event comes from the shared pin clock where clk_sel picks it outside legacy mode, else from the register's own clock term.
      assign ev[i] = use_pin ? pin_edge : (clk_term[i] & ~clk_term_prev[i]);

      always_comb begin
        next_q[i] = q[i];
        if (areset_term[i]) begin
          next_q[i] = 1'b0;
        end else if (ev[i]) begin
          if (pl_act) begin
            if (pins_sync.sel == ODD) begin
              next_q[i] = pins_sync.io[i/2];
            end
          end else if (preset_term) begin
            next_q[i] = 1'b1;
          end else if (t_eff[i]) begin
            next_q[i] = q[i] ^ sum_term[i];
          end else begin
            next_q[i] = sum_term[i];
          end
        end
      end
    end
  endgenerate

  // Twenty registers, two per cell, each with its own sum, clock and reset terms and one shared preset term.
  always_ff @(posedge clk) begin
    if (reset) begin
      q            <= '0;
      reg_feedback <= '0;
    end else begin
      q            <= next_q;
      reg_feedback <= next_q & ~({NR{ctrl.legacy}} & `DRLC_ODD_MASK);
    end
  end

  function automatic logic [NC-1:0] even_of(input logic [NR-1:0] v);
    for (int c = 0; c < NC; c++) begin
      even_of[c] = v[2*c];
    end
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out      <= '0;
      pin_oe       <= '0;
      pin_to_array <= '0;
    end else begin
      pin_out      <= even_of(next_q);
      pin_oe       <= oe_term & ~{NC{pl_act}};
      pin_to_array <= pins_sync.io;
    end
  end

  // APB slave: one wait state, write and read at the edge where pready is high.
  function automatic logic hit(input logic [AW-1:0] a, input logic [11:0] off);
    hit = (a == AW'(off));
  endfunction

  function automatic logic [32:0] rd_word(input logic [AW-1:0] a);
    logic [NR-1:0] msk;
    msk = {NR{ctrl.secure}};
    rd_word = {1'b1, 32'h0000_0000};
    if (hit(a, `DRLC_OFF_CTRL)) begin
      rd_word = {1'b0, 30'h0000_0000, ctrl};
    end else if (hit(a, `DRLC_OFF_DTCFG)) begin
      rd_word = {1'b0, 12'h000, dt_cfg | msk};
    end else if (hit(a, `DRLC_OFF_CLKSEL)) begin
      rd_word = {1'b0, 12'h000, clk_sel | msk};
    end else if (hit(a, `DRLC_OFF_STATE)) begin
      rd_word = {1'b0, 12'h000, q};
    end else if (hit(a, `DRLC_OFF_PINS)) begin
      rd_word = {1'b0, 22'h00_0000, pins_sync.io};
    end
  endfunction

  assign acc = psel & penable;

  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (acc && !pready) begin
      pready  <= 1'b1;
      {pslverr, prdata} <= rd_word(paddr);
      if (pwrite) begin
        prdata <= 32'h0000_0000;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl    <= `DRLC_RST_CTRL;
      dt_cfg  <= `DRLC_RST_CFG;
      clk_sel <= `DRLC_RST_CFG;
    end else if (acc && pready && pwrite) begin
      if (hit(paddr, `DRLC_OFF_CTRL)) begin
        ctrl.legacy <= pwdata[`DRLC_CTRL_LEGACY];
        ctrl.secure <= ctrl.secure | pwdata[`DRLC_CTRL_SECURE];
      end
      if (hit(paddr, `DRLC_OFF_DTCFG)) begin
        dt_cfg <= pwdata[NR-1:0];
      end
      if (hit(paddr, `DRLC_OFF_CLKSEL)) begin
        clk_sel <= pwdata[NR-1:0];
      end
    end
  end

  property p_areset;
    @(posedge clk) disable iff (reset)
    (|areset_term) |=> ((q & $past(areset_term)) == '0);
  endproperty
  a_areset: assert property (p_areset) else $error("reset term did not clear its register");

  property p_preset;
    @(posedge clk) disable iff (reset)
    (preset_term && !pl_act && (|ev) && areset_term == '0) |=> ((q | ~$past(ev)) == '1);
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not set clocked registers");

  property p_dmode;
    @(posedge clk) disable iff (reset)
    (!preset_term && !pl_act) |=> (((q ^ $past(sum_term)) & $past(ev & ~t_eff & ~areset_term)) == '0);
  endproperty
  a_dmode: assert property (p_dmode) else $error("D register did not capture sum term");

  property p_tmode;
    @(posedge clk) disable iff (reset)
    (!preset_term && !pl_act) |=>
      (((q ^ $past(q) ^ $past(sum_term)) & $past(ev & t_eff & ~areset_term)) == '0);
  endproperty
  a_tmode: assert property (p_tmode) else $error("T register did not toggle on one");

  property p_hold;
    @(posedge clk) disable iff (reset)
    1'b1 |=> (((q ^ $past(q)) & $past(~ev & ~areset_term)) == '0);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without clock event");

  property p_preload;
    @(posedge clk) disable iff (reset)
    (pl_act && ev[0] && !pins_sync.sel && !areset_term[0] && !areset_term[1])
      |=> (q[0] == $past(pins_sync.io[0])) && (q[1] == $past(q[1]));
  endproperty
  a_preload: assert property (p_preload) else $error("preload did not load selected register");

  property p_secure;
    @(posedge clk) disable iff (reset)
    (ctrl.secure && acc && !pready && !pwrite && hit(paddr, `DRLC_OFF_DTCFG)) |=> (prdata[NR-1:0] == '1);
  endproperty
  a_secure: assert property (p_secure) else $error("secured readback not all ones");

  property p_legacy;
    @(posedge clk) disable iff (reset)
    ctrl.legacy |=> ((reg_feedback & `DRLC_ODD_MASK) == '0);
  endproperty
  a_legacy: assert property (p_legacy) else $error("second register fed back in legacy mode");

  property p_powerup;
    @(posedge clk) disable iff (reset)
    $fell(reset) |-> (q == '0) && (pin_out == '0);
  endproperty
  a_powerup: assert property (p_powerup) else $error("registers not clear after reset");

  property p_oe;
    @(posedge clk) disable iff (reset)
    1'b1 |=> (pin_oe == ($past(oe_term) & ~{NC{$past(pl_act)}}));
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable does not follow its term");

  property p_fb_path;
    @(posedge clk) disable iff (reset)
    !ctrl.legacy |=> (reg_feedback == q);
  endproperty
  a_fb_path: assert property (p_fb_path) else $error("feedback differs from register state");

  property p_pin_path;
    @(posedge clk) disable iff (reset)
    1'b1 |=> (pin_to_array == $past(pins_sync.io));
  endproperty
  a_pin_path: assert property (p_pin_path) else $error("pin input path does not follow the pins");

  property p_pin_out;
    @(posedge clk) disable iff (reset)
    1'b1 |-> (pin_out == even_of(q));
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin output differs from first register");

  property p_pin_clock;
    @(posedge clk) disable iff (reset)
    (!ctrl.legacy && pin_edge) |-> ((clk_sel & ~ev) == '0);
  endproperty
  a_pin_clock: assert property (p_pin_clock) else $error("pin clock edge missed a register");

  property p_term_clock;
    @(posedge clk) disable iff (reset)
    1'b1 |-> ((clk_term & ~clk_term_prev & ~clk_sel & ~ev) == '0);
  endproperty
  a_term_clock: assert property (p_term_clock) else $error("clock term edge missed a register");

  property p_legacy_pin;
    @(posedge clk) disable iff (reset)
    (ctrl.legacy && ((clk_term & ~clk_term_prev) == '0)) |-> (ev == '0);
  endproperty
  a_legacy_pin: assert property (p_legacy_pin) else $error("pin clock used in legacy mode");

  property p_preload_odd;
    @(posedge clk) disable iff (reset)
    (pl_act && ev[1] && pins_sync.sel && !areset_term[0] && !areset_term[1])
      |=> (q[1] == $past(pins_sync.io[0])) && (q[0] == $past(q[0]));
  endproperty
  a_preload_odd: assert property (p_preload_odd) else $error("preload did not load second register");

  property p_oe_preload;
    @(posedge clk) disable iff (reset)
    pl_act |=> (pin_oe == '0);
  endproperty
  a_oe_preload: assert property (p_oe_preload) else $error("pin driven during preload");

  property p_secure_clk;
    @(posedge clk) disable iff (reset)
    (ctrl.secure && acc && !pready && !pwrite && hit(paddr, `DRLC_OFF_CLKSEL)) |=> (prdata[NR-1:0] == '1);
  endproperty
  a_secure_clk: assert property (p_secure_clk) else $error("secured clock select not all ones");

  property p_secure_stick;
    @(posedge clk) disable iff (reset)
    ctrl.secure |=> ctrl.secure;
  endproperty
  a_secure_stick: assert property (p_secure_stick) else $error("security bit was cleared");

  property p_areset_pin;
    @(posedge clk) disable iff (reset)
    areset_term[0] |=> !pin_out[0];
  endproperty
  a_areset_pin: assert property (p_areset_pin) else $error("reset term did not clear pin output");

endmodule
`default_nettype wire
